// [include/mmec_pkg.sv]
// mmec_pkg: constants and types for the multi-mode event counter
// assumes one 100 MHz clock shared by all users
package mmec_pkg;
   localparam int          COUNT_WIDTH   = 32;
   localparam int          TB_DIV        = 10;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          TB_PERIOD_NS  = 100;
   localparam int          TB_CYCLES     = (TB_PERIOD_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
   localparam logic [31:0] COUNT_RESET   = 32'h00000000;
   localparam logic [1:0]  MODE_GATED    = 2'h0;
   localparam logic [1:0]  MODE_UPDOWN   = 2'h1;
   localparam logic [1:0]  MODE_PERIOD   = 2'h2;
   typedef enum logic [1:0] {
      MMEC_GATED,
      MMEC_UPDOWN,
      MMEC_PERIOD,
      MMEC_IDLE
   } mmec_mode_type;
endpackage

// [hw/mmec_edge_sync.sv]
// mmec_edge_sync: two-flop synchroniser with rise and fall detect
// assumes input may be asynchronous to clk
`timescale 1ns/100ps
module mmec_edge_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // pin in, conditioned out
   input  wire logic pinIn,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;

   always_comb begin
      sync_d = {sync_q[1:0], pinIn};
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= sync_d;
      end
   end

   // only stages 1 and 2 feed logic
   assign level = sync_q[1];
   assign rise  = sync_q[1] & ~sync_q[2];
   assign fall  = ~sync_q[1] & sync_q[2];
endmodule

// [hw/mmec_counter.sv]
// mmec_counter: one counter channel, gated, up/down and period modes
// assumes source, gate, direction pins from external generators
//
// Functional notes
// - gated mode counts source pulses while gate active
// - gated mode holds count while gate inactive
// - counting modes output count each sample tick
// - report zero before gate first active
// - no pulses between samples gives same count
// - optional source inversion counts falling edges
// - optional clear of counter on start
// - gated mode has count direction setting, up or down
// - up/down mode counts each source rising edge
// - direction high increments the count
// - direction low decrements the count
// - period mode counts time base between edges
// - period end latches result, restarts from zero
// - period mode outputs latched result each sample
`timescale 1ns/100ps
module mmec_counter
   import mmec_pkg::*;
#(
   parameter int WIDTH    = mmec_pkg::COUNT_WIDTH,
   parameter int TB_COUNT = mmec_pkg::TB_CYCLES
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // configuration
   input  wire logic [1:0]       mode,
   input  wire logic             invertSource,
   input  wire logic             clearOnStart,
   input  wire logic             countDown,
   input  wire logic             startMeasure,
   input  wire logic             sampleClock,
   // external signals
   input  wire logic             counterSourceInput,
   input  wire logic             gateInput,
   input  wire logic             directionAuxInput,
   // results
   output logic [WIDTH-1:0]      sampleValue,
   output logic                  sampleValid,
   output logic                  periodNew
);
   import mmec_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // input conditioning
   logic srcLevel, srcRise, gateLevel, auxLevel;
   logic srcFallUnused, gateRiseUnused, gateFallUnused;
   logic auxRiseUnused, auxFallUnused;
   logic srcPin;

   assign srcPin = counterSourceInput ^ invertSource;

   mmec_edge_sync uSrc (
      .clk    (clk),
      .resetn (resetn),
      .pinIn  (srcPin),
      .level  (srcLevel),
      .rise   (srcRise),
      .fall   (srcFallUnused)
   );
   mmec_edge_sync uGate (
      .clk    (clk),
      .resetn (resetn),
      .pinIn  (gateInput),
      .level  (gateLevel),
      .rise   (gateRiseUnused),
      .fall   (gateFallUnused)
   );
   mmec_edge_sync uAux (
      .clk    (clk),
      .resetn (resetn),
      .pinIn  (directionAuxInput),
      .level  (auxLevel),
      .rise   (auxRiseUnused),
      .fall   (auxFallUnused)
   );

   ////////////////////////////////////////////////////////////////////
   // time base divider
   logic [15:0] tbCnt_q, tbCnt_d;
   logic        tbTick;

   always_comb begin
      tbTick  = (tbCnt_q == 16'(TB_COUNT - 1));
      tbCnt_d = tbTick ? 16'h0000 : tbCnt_q + 16'h0001;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tbCnt_q <= 16'h0000;
      end else begin
         tbCnt_q <= tbCnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // counting core
   logic [WIDTH-1:0] count_q, count_d;
   logic [WIDTH-1:0] result_q, result_d;
   logic [WIDTH-1:0] sample_q, sample_d;
   logic             valid_q, valid_d;
   logic             pnew_q, pnew_d;
   logic             armed_q, armed_d;

   always_comb begin
      count_d  = count_q;
      result_d = result_q;
      sample_d = sample_q;
      valid_d  = 1'b0;
      pnew_d   = 1'b0;
      armed_d  = armed_q;
      if (startMeasure) begin
         if (clearOnStart) begin
            count_d  = WIDTH'(COUNT_RESET);
            result_d = WIDTH'(COUNT_RESET);
         end
         // restart period timing from the next source edge
         armed_d = 1'b0;
      end else begin
         case (mode)
            MODE_GATED: begin
               if (srcRise && gateLevel) begin
                  count_d = countDown ? count_q - 1'b1 : count_q + 1'b1;
               end
            end
            MODE_UPDOWN: begin
               if (srcRise) begin
                  count_d = auxLevel ? count_q + 1'b1 : count_q - 1'b1;
               end
            end
            MODE_PERIOD: begin
               if (srcRise) begin
                  if (armed_q) begin
                     result_d = count_q;
                     pnew_d   = 1'b1;
                  end
                  count_d = WIDTH'(COUNT_RESET);
                  armed_d = 1'b1;
               end else if (tbTick && armed_q) begin
                  count_d = count_q + 1'b1;
               end
            end
            default: begin
               count_d = count_q;
            end
         endcase
      end
      if (sampleClock) begin
         valid_d = 1'b1;
         sample_d = (mode == MODE_PERIOD) ? result_q : count_q;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_q  <= '0;
         result_q <= '0;
         sample_q <= '0;
         valid_q  <= 1'b0;
         pnew_q   <= 1'b0;
         armed_q  <= 1'b0;
      end else begin
         count_q  <= count_d;
         result_q <= result_d;
         sample_q <= sample_d;
         valid_q  <= valid_d;
         pnew_q   <= pnew_d;
         armed_q  <= armed_d;
      end
   end

   assign sampleValue = sample_q;
   assign sampleValid = valid_q;
   assign periodNew   = pnew_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   gated_hold_a: assert property (
      (mode == MODE_GATED && !startMeasure && !gateLevel)
      |=> count_q == $past(count_q))
      else $error("gated count moved with gate low");
   gated_count_a: assert property (
      (mode == MODE_GATED && !startMeasure && gateLevel && srcRise
       && !countDown) |=> count_q == $past(count_q) + 1'b1)
      else $error("gated count missed a pulse");
   updown_up_a: assert property (
      (mode == MODE_UPDOWN && !startMeasure && srcRise && auxLevel)
      |=> count_q == $past(count_q) + 1'b1)
      else $error("up count missed");
   updown_down_a: assert property (
      (mode == MODE_UPDOWN && !startMeasure && srcRise && !auxLevel)
      |=> count_q == $past(count_q) - 1'b1)
      else $error("down count missed");
   updown_idle_a: assert property (
      (mode == MODE_UPDOWN && !startMeasure && !srcRise)
      |=> count_q == $past(count_q))
      else $error("up/down moved without edge");
   start_clear_a: assert property (
      (startMeasure && clearOnStart) |=> count_q == '0 && result_q == '0)
      else $error("start did not clear");
   period_latch_a: assert property (
      (mode == MODE_PERIOD && !startMeasure && srcRise && armed_q)
      |=> result_q == $past(count_q) && count_q == '0 && periodNew)
      else $error("period not latched");
   sample_out_a: assert property (
      (sampleClock && mode != MODE_PERIOD)
      |=> sampleValid && sampleValue == $past(count_q))
      else $error("sample did not show count");
   sample_period_a: assert property (
      (sampleClock && mode == MODE_PERIOD)
      |=> sampleValid && sampleValue == $past(result_q))
      else $error("sample did not show result");
   period_repeat_a: assert property (
      (mode == MODE_PERIOD && !startMeasure && !(srcRise && armed_q))
      |=> result_q == $past(result_q))
      else $error("result changed without period");

   gated_cov_c:  cover property (mode == MODE_GATED && srcRise && gateLevel);
   down_cov_c:   cover property (mode == MODE_UPDOWN && srcRise && !auxLevel);
   period_cov_c: cover property (periodNew ##[1:200] periodNew);
   sample_cov_c: cover property (sampleValid && sampleValue != '0);
endmodule

// [testbench/mmec_pin_source.sv]
// mmec_pin_source: external source, gate and direction pins
// assumes clk is the counter clock; pins move 1 ns after an edge
`timescale 1ns/100ps
module mmec_pin_source (
   // clock
   input  wire logic clk,
   // pins
   output logic      srcPin,
   output logic      gatePin,
   output logic      dirPin
);
   initial begin
      srcPin = 1'b0;
      gatePin = 1'b0;
      dirPin = 1'b0;
   end
   task automatic setPins(input logic s, input logic g, input logic d);
      srcPin = s;
      gatePin = g;
      dirPin = d;
   endtask
   // n pulses away from idle; hi >= 2 keeps each level seen
   task automatic pulses(input int n, input logic idle, input int hi);
      for (int i = 0; i < n; i++) begin
         repeat (hi) @(posedge clk);
         #1 srcPin = ~idle;
         repeat (hi) @(posedge clk);
         #1 srcPin = idle;
      end
   endtask
endmodule

// [testbench/test_multi_mode_event_counter.sv]
// test_multi_mode_event_counter: self-checking bench for mmec_counter
// assumes mmec_pkg compiled first; pins come from mmec_pin_source
`timescale 1ns/100ps
module test_multi_mode_event_counter;
   import mmec_pkg::*;
   logic        clk, resetn, invertSource, clearOnStart, countDown;
   logic        startMeasure, sampleClock, sampleValid, periodNew;
   logic [1:0]  mode;
   logic        srcPin, gatePin, dirPin;
   logic [31:0] sampleValue;
   int          bad_count, num_checks, newCount;
   // counts latched periods seen on the output pulse
   always @(posedge clk) begin
      if (periodNew === 1'b1)
         newCount++;
   end
   mmec_pin_source src_u (
      .clk     (clk),
      .srcPin  (srcPin),
      .gatePin (gatePin),
      .dirPin  (dirPin)
   );
   mmec_counter dut_u (
      .clk                (clk),
      .resetn             (resetn),
      .mode               (mode),
      .invertSource       (invertSource),
      .clearOnStart       (clearOnStart),
      .countDown          (countDown),
      .startMeasure       (startMeasure),
      .sampleClock        (sampleClock),
      .counterSourceInput (srcPin),
      .gateInput          (gatePin),
      .directionAuxInput  (dirPin),
      .sampleValue        (sampleValue),
      .sampleValid        (sampleValid),
      .periodNew          (periodNew)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic test_done;
      $display("checks %0d bad %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic start;
      @(posedge clk);
      #1 startMeasure = 1'b1;
      @(posedge clk);
      #1 startMeasure = 1'b0;
   endtask
   // settle, pulse the sample request, compare the answer
   task automatic sample(input logic [31:0] want);
      int k;
      repeat (5) @(posedge clk);
      #1 sampleClock = 1'b1;
      @(posedge clk);
      #1 sampleClock = 1'b0;
      k = 0;
      while (sampleValid !== 1'b1 && k < 4) begin
         @(posedge clk);
         #1 k++;
      end
      if (k == 4) begin
         bad_count++;
         test_done();
      end
      check({31'h0, sampleValid}, 32'h1);
      check(sampleValue, want);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      mode = MODE_GATED;
      invertSource = 1'b0;
      clearOnStart = 1'b1;
      countDown = 1'b0;
      startMeasure = 1'b0;
      sampleClock = 1'b0;
      bad_count = 0;
      num_checks = 0;
      newCount = 0;
      repeat (16) @(posedge clk);
      #1 check(sampleValue, 32'h0);
      resetn = 1'b1;
      repeat (4) @(posedge clk);
      start();
      src_u.pulses(3, 1'b0, 3);
      sample(32'h0);
      src_u.setPins(1'b0, 1'b1, 1'b0);
      src_u.pulses(3, 1'b0, 3);
      sample(32'h3);
      sample(32'h3);
      src_u.setPins(1'b0, 1'b0, 1'b0);
      src_u.pulses(2, 1'b0, 3);
      sample(32'h3);
      clearOnStart = 1'b0;
      start();
      sample(32'h3);
      clearOnStart = 1'b1;
      start();
      sample(32'h0);
      src_u.setPins(1'b1, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      #1 invertSource = 1'b1;
      repeat (4) @(posedge clk);
      start();
      src_u.pulses(2, 1'b1, 3);
      sample(32'h2);
      src_u.setPins(1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge clk);
      #1 invertSource = 1'b0;
      mode = MODE_UPDOWN;
      src_u.setPins(1'b0, 1'b0, 1'b1);
      start();
      src_u.pulses(4, 1'b0, 3);
      src_u.setPins(1'b0, 1'b0, 1'b0);
      src_u.pulses(1, 1'b0, 3);
      sample(32'h3);
      mode = MODE_PERIOD;
      start();
      newCount = 0;
      src_u.pulses(3, 1'b0, 25);
      sample(32'h5);
      sample(32'h5);
      check(32'(newCount), 32'h2);
      mode = MODE_GATED;
      countDown = 1'b1;
      start();
      src_u.setPins(1'b0, 1'b1, 1'b0);
      src_u.pulses(2, 1'b0, 3);
      sample(32'hFFFFFFFE);
      test_done();
   end
endmodule
